//--- rtl/serial_port_modem_handshake.sv
// Serial port with terminal/modem handshake roles and monitor command channel
`timescale 1ns/1ps
`default_nettype none
module serial_port_modem_handshake #(
    parameter int BIT_CYCLES = serial_port_pkg::BIT_CYCLES,
    parameter int TURN_CYCLES = serial_port_pkg::TURN_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    // Configuration
    input wire serial_port_pkg::role_e role_in,
    input wire logic monitor_mode_in,
    input wire logic current_loop_mode_in,
    // Outgoing transfer
    input wire logic xfer_start_in,
    input wire logic tx_valid_in,
    input wire logic [7:0] tx_data_in,
    input wire logic tx_last_in,
    output logic tx_ready_out,
    // Incoming data
    output logic rx_valid_out,
    output logic [7:0] rx_data_out,
    // Monitor commands
    output logic cmd_valid_out,
    output logic [7:0] cmd_data_out,
    output logic cmd_end_out,
    input wire logic cmd_done_in,
    input wire logic cmd_ok_in,
    // Serial data pins
    output logic line_data_out,
    input wire logic line_data_in,
    // Modem control pins
    output logic rts_out,
    output logic dtr_out,
    input wire logic cts_in,
    input wire logic carrier_detect_in,
    output logic carrier_detect_out,
    input wire logic dtr_in,
    output logic dsr_out,
    input wire logic rts_in,
    output logic cts_out,
    output logic loop_select_out
);
    import serial_port_pkg::*;

    localparam int BITW = $clog2(BIT_CYCLES + 1);
    localparam int TURNW = $clog2(TURN_CYCLES + 1);

    function automatic logic period_end(input logic [BITW-1:0] cnt, input int limit);
        period_end = (cnt == BITW'(limit - 1));
    endfunction

    char_link_if link ();

    talk_state_e talk_state;
    rx_state_e rx_state;
    logic [BITW-1:0] rx_cyc;
    logic [2:0] rx_bit;
    logic [7:0] rx_shift;
    logic rx_done;
    logic [7:0] rx_char;
    logic [TURNW-1:0] turn_cnt;
    logic in_cmd;
    logic reply_pending;
    logic last_ok;

    logic talker_role;
    logic clear_to_go;
    logic rx_enable;
    logic user_accept;
    logic reply_send;
    logic drain_done;
    logic enq_seen;

    assign talker_role = (role_in == ROLE_TERM_TALK) || (role_in == ROLE_MODEM_TALK);

    always_comb begin
        case (role_in)
            ROLE_TERM_TALK: clear_to_go = cts_in;
            ROLE_MODEM_TALK: clear_to_go = dtr_in;
            default: clear_to_go = 1'b0;
        endcase
    end

    // Carrier gating only applies to the terminal listener; monitor link has no controls
    always_comb begin
        if (monitor_mode_in) begin
            rx_enable = 1'b1;
        end else begin
            case (role_in)
                ROLE_TERM_LISTEN: rx_enable = carrier_detect_in;
                ROLE_MODEM_LISTEN: rx_enable = 1'b1;
                default: rx_enable = 1'b0;
            endcase
        end
    end

    assign user_accept = tx_valid_in && tx_ready_out;
    assign reply_send = monitor_mode_in && reply_pending && link.ready && !user_accept;
    assign drain_done = (talk_state == TALK_DRAIN) && link.ready;
    assign link.valid = user_accept || reply_send;
    assign link.data = reply_send ? (last_ok ? CHAR_ACK : CHAR_NAK) : tx_data_in;
    assign enq_seen = monitor_mode_in && rx_done && !in_cmd && (rx_char == CHAR_ENQ);

    char_serializer #(.BIT_CYCLES(BIT_CYCLES)) u_serializer (
        .clk_sys_in(clk_sys_in),
        .rst_b_in(rst_b_in),
        .link(link),
        .line_out(line_data_out)
    );

    // Talker sequencing
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            talk_state <= TALK_IDLE;
        end else begin
            case (talk_state)
                TALK_IDLE: begin
                    if (xfer_start_in && talker_role && !monitor_mode_in) begin
                        talk_state <= TALK_WAIT_CLEAR;
                    end
                end
                TALK_WAIT_CLEAR: begin
                    if (clear_to_go) begin
                        talk_state <= TALK_SEND;
                    end
                end
                TALK_SEND: begin
                    if (user_accept && tx_last_in) begin
                        talk_state <= TALK_DRAIN;
                    end
                end
                TALK_DRAIN: begin
                    if (drain_done) begin
                        talk_state <= TALK_IDLE;
                    end
                end
                default: talk_state <= TALK_IDLE;
            endcase
        end
    end

    // Registered ready drops the cycle after a hand-off, while the serializer is busy
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tx_ready_out <= 1'b0;
        end else begin
            tx_ready_out <= (talk_state == TALK_SEND) && clear_to_go && link.ready
                && !user_accept && !reply_send && !monitor_mode_in;
        end
    end

    // Terminal control lines
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rts_out <= 1'b0;
            dtr_out <= 1'b0;
        end else if (talk_state == TALK_IDLE && xfer_start_in && !monitor_mode_in
                && role_in == ROLE_TERM_TALK) begin
            rts_out <= 1'b1;
            dtr_out <= 1'b1;
        end else if (drain_done) begin
            rts_out <= 1'b0;
            dtr_out <= 1'b0;
        end
    end

    // Modem carrier output
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            carrier_detect_out <= 1'b0;
        end else if (talk_state == TALK_IDLE && xfer_start_in && !monitor_mode_in
                && role_in == ROLE_MODEM_TALK) begin
            carrier_detect_out <= 1'b1;
        end else if (drain_done) begin
            carrier_detect_out <= 1'b0;
        end
    end

    // Data-set-ready returned from the partner's terminal-ready
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            dsr_out <= 1'b0;
        end else begin
            dsr_out <= role_in[1] && dtr_in;
        end
    end

    // Turnaround is the documented worst case; a shorter TURN_CYCLES is also legal
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cts_out <= 1'b0;
            turn_cnt <= '0;
        end else if (role_in != ROLE_MODEM_LISTEN || monitor_mode_in || !rts_in) begin
            cts_out <= 1'b0;
            turn_cnt <= '0;
        end else if (turn_cnt == TURNW'(TURN_CYCLES - 1)) begin
            cts_out <= 1'b1;
        end else begin
            turn_cnt <= turn_cnt + 1'b1;
        end
    end

    // Interface selection only steers the line driver; framing logic is shared
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            loop_select_out <= 1'b0;
        end else begin
            loop_select_out <= current_loop_mode_in;
        end
    end

    // Receiver; losing the enable mid-character discards that character
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rx_state <= RX_IDLE;
            rx_cyc <= '0;
            rx_bit <= 3'h0;
            rx_shift <= 8'h00;
            rx_done <= 1'b0;
            rx_char <= 8'h00;
        end else begin
            rx_done <= 1'b0;
            if (!rx_enable) begin
                rx_state <= RX_IDLE;
                rx_cyc <= '0;
            end else begin
                case (rx_state)
                    RX_IDLE: begin
                        rx_cyc <= '0;
                        if (line_data_in == SPACE) begin
                            rx_state <= RX_START;
                        end
                    end
                    RX_START: begin
                        if (period_end(rx_cyc, BIT_CYCLES / 2)) begin
                            rx_cyc <= '0;
                            rx_bit <= 3'h0;
                            rx_state <= (line_data_in == SPACE) ? RX_DATA : RX_IDLE;
                        end else begin
                            rx_cyc <= rx_cyc + 1'b1;
                        end
                    end
                    RX_DATA: begin
                        if (period_end(rx_cyc, BIT_CYCLES)) begin
                            rx_cyc <= '0;
                            rx_shift <= {line_data_in, rx_shift[7:1]};
                            rx_bit <= rx_bit + 3'h1;
                            if (rx_bit == 3'(DATA_BITS - 1)) begin
                                rx_state <= RX_STOP;
                            end
                        end else begin
                            rx_cyc <= rx_cyc + 1'b1;
                        end
                    end
                    RX_STOP: begin
                        if (period_end(rx_cyc, BIT_CYCLES)) begin
                            rx_cyc <= '0;
                            rx_state <= RX_IDLE;
                            rx_done <= (line_data_in == MARK);
                            rx_char <= rx_shift;
                        end else begin
                            rx_cyc <= rx_cyc + 1'b1;
                        end
                    end
                    default: rx_state <= RX_IDLE;
                endcase
            end
        end
    end

    // Data characters go to the user outside monitor mode
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rx_valid_out <= 1'b0;
            rx_data_out <= 8'h00;
        end else begin
            rx_valid_out <= rx_done && !monitor_mode_in;
            if (rx_done && !monitor_mode_in) begin
                rx_data_out <= rx_char;
            end
        end
    end

    // Command characters stream out one per received character, so order is kept
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            in_cmd <= 1'b0;
            cmd_valid_out <= 1'b0;
            cmd_end_out <= 1'b0;
            cmd_data_out <= 8'h00;
        end else begin
            cmd_valid_out <= 1'b0;
            cmd_end_out <= 1'b0;
            if (!monitor_mode_in) begin
                in_cmd <= 1'b0;
            end else if (rx_done && in_cmd) begin
                if (rx_char == CHAR_CMD_END) begin
                    in_cmd <= 1'b0;
                    cmd_end_out <= 1'b1;
                end else begin
                    cmd_valid_out <= 1'b1;
                    cmd_data_out <= rx_char;
                end
            end else if (rx_done && rx_char == CHAR_CMD_PREFIX) begin
                in_cmd <= 1'b1;
            end
        end
    end

    // Local and remote completions share one outcome flag
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            last_ok <= LAST_OK_RESET;
        end else if (cmd_done_in) begin
            last_ok <= cmd_ok_in;
        end
    end

    // A new enquiry wins over the clear of one being answered
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            reply_pending <= 1'b0;
        end else begin
            reply_pending <= enq_seen || (reply_pending && !reply_send && monitor_mode_in);
        end
    end

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_b_in);

    a_idle_line_mark: assert property (
        (talk_state == TALK_IDLE && link.ready && !link.valid) |=> line_data_out == MARK)
        else $error("line not at mark while idle");
    a_cts_before_send: assert property (
        (user_accept && role_in == ROLE_TERM_TALK) |-> cts_in && rts_out)
        else $error("character sent without clear-to-send");
    a_start_raises_rts: assert property (
        (talk_state == TALK_IDLE && xfer_start_in && !monitor_mode_in
            && role_in == ROLE_TERM_TALK) |=> rts_out && dtr_out)
        else $error("start did not raise rts and dtr");
    a_rts_drop_end: assert property (
        (drain_done && role_in == ROLE_TERM_TALK) |=> !rts_out && !dtr_out)
        else $error("rts held after last data");
    a_rx_carrier_gate: assert property (
        (!monitor_mode_in && role_in == ROLE_TERM_LISTEN && !carrier_detect_in)
            |=> rx_state == RX_IDLE && !rx_done)
        else $error("receiver active without carrier");
    a_dsr_copy: assert property (
        role_in[1] |=> dsr_out == $past(dtr_in))
        else $error("dsr not following dtr");
    a_dtr_gate: assert property (
        (user_accept && role_in == ROLE_MODEM_TALK) |-> dtr_in)
        else $error("modem talker sent without dtr");
    a_carrier_on: assert property (
        (talk_state == TALK_IDLE && xfer_start_in && !monitor_mode_in
            && role_in == ROLE_MODEM_TALK) |=> carrier_detect_out)
        else $error("carrier not raised at start");
    a_carrier_off: assert property (
        (drain_done && carrier_detect_out) |=> !carrier_detect_out)
        else $error("carrier held after final character");
    a_cts_turnaround: assert property (
        $rose(cts_out) |-> $past(turn_cnt) == TURNW'(TURN_CYCLES - 1) && $past(rts_in))
        else $error("cts raised off the turnaround count");
    a_cts_follows_rts: assert property (
        (role_in == ROLE_MODEM_LISTEN && !rts_in) |=> !cts_out)
        else $error("cts held after rts dropped");
    a_enq_reply: assert property (
        (enq_seen && link.ready && !user_accept) |=> reply_send ##1 !link.ready)
        else $error("enquiry not answered");

    c_term_talk: cover property (drain_done && role_in == ROLE_TERM_TALK);
    c_modem_talk: cover property (drain_done && role_in == ROLE_MODEM_TALK);
    c_rx_char: cover property (rx_valid_out);
    c_cmd_end: cover property (cmd_end_out);
    c_reply: cover property (reply_send && last_ok);
endmodule
`default_nettype wire

//--- rtl/serial_port_pkg.sv
// Shared constants and types for the serial port handshake block
package serial_port_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int BAUD_RATE = 9600;
    localparam int BIT_CYCLES = CLK_HZ / BAUD_RATE;
    localparam int TURN_MAX_MS = 100;
    localparam int TURN_CYCLES = TURN_MAX_MS * (CLK_HZ / 1000);
    localparam int DATA_BITS = 8;
    localparam logic [3:0] FRAME_SHIFTS = 4'h9;
    localparam logic MARK = 1'b1;
    localparam logic SPACE = 1'b0;
    localparam logic [7:0] CHAR_ENQ = 8'h05;
    localparam logic [7:0] CHAR_ACK = 8'h06;
    localparam logic [7:0] CHAR_NAK = 8'h15;
    localparam logic [7:0] CHAR_CMD_PREFIX = 8'h5C;
    localparam logic [7:0] CHAR_CMD_END = 8'h0D;
    localparam logic LAST_OK_RESET = 1'b0;

    typedef enum logic [1:0] {
        ROLE_TERM_TALK = 2'b00,
        ROLE_TERM_LISTEN = 2'b01,
        ROLE_MODEM_TALK = 2'b10,
        ROLE_MODEM_LISTEN = 2'b11
    } role_e;

    typedef enum logic [1:0] {
        TALK_IDLE = 2'b00,
        TALK_WAIT_CLEAR = 2'b01,
        TALK_SEND = 2'b10,
        TALK_DRAIN = 2'b11
    } talk_state_e;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b10,
        RX_STOP = 2'b11
    } rx_state_e;
endpackage

//--- rtl/char_link_if.sv
// Character hand-off between the port control logic and the serializer
`timescale 1ns/1ps
`default_nettype none
interface char_link_if;
    logic valid;
    logic ready;
    logic [7:0] data;

    modport src (output valid, output data, input ready);
    modport ser (input valid, input data, output ready);
endinterface
`default_nettype wire

//--- rtl/char_serializer.sv
// Asynchronous character serializer: start bit, eight data bits LSB first, one stop bit
`timescale 1ns/1ps
`default_nettype none
module char_serializer #(
    parameter int BIT_CYCLES = serial_port_pkg::BIT_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    // Character source
    char_link_if.ser link,
    // Serial line
    output logic line_out
);
    import serial_port_pkg::*;

    logic active;
    logic [7:0] shreg;
    logic [3:0] shifts_left;
    logic [$clog2(BIT_CYCLES+1)-1:0] cyc;

    assign link.ready = !active;

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            active <= 1'b0;
            shreg <= 8'hFF;
            shifts_left <= 4'h0;
            cyc <= '0;
            line_out <= MARK;
        end else if (!active) begin
            line_out <= MARK;
            cyc <= '0;
            if (link.valid) begin
                active <= 1'b1;
                shreg <= link.data;
                shifts_left <= FRAME_SHIFTS;
                line_out <= SPACE;
            end
        end else if (cyc == ($bits(cyc))'(BIT_CYCLES - 1)) begin
            cyc <= '0;
            if (shifts_left == 4'h0) begin
                active <= 1'b0;
                line_out <= MARK;
            end else begin
                // Ones shift in behind the data so the last shift is the stop bit
                line_out <= shreg[0];
                shreg <= {MARK, shreg[7:1]};
                shifts_left <= shifts_left - 4'h1;
            end
        end else begin
            cyc <= cyc + 1'b1;
        end
    end
endmodule
`default_nettype wire

//--- test/serial_partner.sv
// Far-side serial equipment: frames characters toward the port and decodes its output
`timescale 1ns/1ps
`default_nettype none
module serial_partner #(
    parameter int BIT_CYCLES = 8
) (
    // Clock
    input wire logic clk_sys_in,
    // Serial data
    input wire logic line_in,
    output logic line_out
);
    logic [7:0] got_q[$];
    logic [7:0] sh;

    initial line_out = 1'b1;

    // Start, eight data bits LSB first, stop; the stop bit is the idle mark level
    task automatic send_char(input logic [7:0] c);
        logic [9:0] f;
        f = {1'b1, c, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge clk_sys_in);
            line_out = f[i];
            repeat (BIT_CYCLES - 1) @(negedge clk_sys_in);
        end
    endtask

    // Samples mid-bit; a frame without a mark stop bit is dropped
    always begin
        @(negedge line_in);
        repeat (BIT_CYCLES / 2) @(posedge clk_sys_in);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYCLES) @(posedge clk_sys_in);
            sh[i] = line_in;
        end
        repeat (BIT_CYCLES) @(posedge clk_sys_in);
        if (line_in === 1'b1) got_q.push_back(sh);
    end
endmodule
`default_nettype wire

//--- test/serial_port_modem_handshake_test.sv
// Self-checking bench for the serial port handshake block
`timescale 1ns/1ps
`default_nettype none
module serial_port_modem_handshake_test;
    import serial_port_pkg::*;
    localparam int BC = 8;
    localparam int TC = 10;
    logic clk_sys_in = 1'b0;
    logic rst_b_in = 1'b0;
    role_e role = ROLE_TERM_TALK;
    logic monitor = 1'b0;
    logic loop_mode = 1'b0;
    logic start = 1'b0;
    logic tx_valid = 1'b0;
    logic tx_last = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic cmd_done = 1'b0;
    logic cmd_ok = 1'b0;
    logic cts = 1'b1;
    logic cd_in = 1'b1;
    logic dtr_in = 1'b1;
    logic rts_in = 1'b0;
    logic line_in;
    logic tx_ready, rx_valid, cmd_valid, cmd_end, line_out, rts, dtr, cd_out, dsr, cts_out;
    logic loop_sel;
    logic [7:0] rx_data, cmd_data;
    logic [7:0] exp_q[$];
    logic [7:0] line_q[$];
    logic [31:0] lfsr = 32'h35F5;
    int errors = 0;
    int n_checks = 0;
    int n_end = 0;

    always #5 clk_sys_in = ~clk_sys_in;

    serial_port_modem_handshake #(.BIT_CYCLES(BC), .TURN_CYCLES(TC)) i_dut (
        .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .role_in(role),
        .monitor_mode_in(monitor), .current_loop_mode_in(loop_mode),
        .xfer_start_in(start), .tx_valid_in(tx_valid), .tx_data_in(tx_data),
        .tx_last_in(tx_last), .tx_ready_out(tx_ready), .rx_valid_out(rx_valid),
        .rx_data_out(rx_data), .cmd_valid_out(cmd_valid), .cmd_data_out(cmd_data),
        .cmd_end_out(cmd_end), .cmd_done_in(cmd_done), .cmd_ok_in(cmd_ok),
        .line_data_out(line_out), .line_data_in(line_in), .rts_out(rts), .dtr_out(dtr),
        .cts_in(cts), .carrier_detect_in(cd_in), .carrier_detect_out(cd_out),
        .dtr_in(dtr_in), .dsr_out(dsr), .rts_in(rts_in), .cts_out(cts_out),
        .loop_select_out(loop_sel));

    serial_partner #(.BIT_CYCLES(BC)) i_partner (
        .clk_sys_in(clk_sys_in), .line_in(line_out), .line_out(line_in));

    function automatic logic [7:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[7:0];
    endfunction

    function automatic logic [7:0] pop_exp();
        return (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
    endfunction

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("FAIL at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        check_byte({7'h00, got}, {7'h00, exp});
    endtask

    task automatic finish_test();
        if (errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Received characters and command characters are matched against the model queue;
    // registered pulses are looked at mid-cycle, away from the edge that moves them
    always @(negedge clk_sys_in) begin
        if (rx_valid === 1'b1) check_byte(rx_data, pop_exp());
        if (cmd_valid === 1'b1) check_byte(cmd_data, pop_exp());
        if (cmd_end === 1'b1) n_end++;
    end

    task automatic wait_cycles(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask

    task automatic check_line();
        while (line_q.size() > 0) begin
            check_byte((i_partner.got_q.size() > 0) ? i_partner.got_q.pop_front() : 8'hXX,
                line_q.pop_front());
        end
        check_bit(i_partner.got_q.size() == 0, 1'b1);
    endtask

    task automatic send_tx(input logic [7:0] c, input logic last);
        int n;
        n = 0;
        @(negedge clk_sys_in);
        tx_data = c;
        tx_last = last;
        tx_valid = 1'b1;
        line_q.push_back(c);
        // Ready is registered, so seen high here it is taken at the next rising edge
        while (tx_ready !== 1'b1 && n < 400) begin
            @(negedge clk_sys_in);
            n++;
        end
        @(negedge clk_sys_in);
        tx_valid = 1'b0;
        check_bit(n < 400, 1'b1);
    endtask

    task automatic talk(input role_e r);
        role = r;
        cts = 1'b0;
        dtr_in = 1'b0;
        @(negedge clk_sys_in);
        start = 1'b1;
        @(negedge clk_sys_in);
        start = 1'b0;
        check_bit(rts, r == ROLE_TERM_TALK);
        check_bit(dtr, r == ROLE_TERM_TALK);
        check_bit(cd_out, r == ROLE_MODEM_TALK);
        wait_cycles(4 * BC);
        check_bit(tx_ready, 1'b0);
        check_bit(line_out, 1'b1);
        check_bit(dsr, 1'b0);
        cts = 1'b1;
        dtr_in = 1'b1;
        for (int i = 0; i < 3; i++) send_tx(rnd(), i == 2);
        check_bit(rts | cd_out, 1'b1);
        check_bit(dsr, r[1]);
        wait_cycles(12 * BC);
        check_bit(rts, 1'b0);
        check_bit(dtr, 1'b0);
        check_bit(cd_out, 1'b0);
        check_bit(line_out, 1'b1);
        check_line();
    endtask

    task automatic cmd_finish(input logic ok);
        @(negedge clk_sys_in);
        cmd_done = 1'b1;
        cmd_ok = ok;
        @(negedge clk_sys_in);
        cmd_done = 1'b0;
        i_partner.send_char(CHAR_ENQ);
        line_q.push_back(ok ? 8'h06 : 8'h15);
        wait_cycles(14 * BC);
        check_line();
    endtask

    initial begin
        logic [7:0] b;
        // Reset level is present from time zero, so the first edge applies it
        @(negedge clk_sys_in);
        check_bit(line_out, 1'b1);
        check_bit(cts_out, 1'b0);
        wait_cycles(2);
        rst_b_in = 1'b1;
        talk(ROLE_TERM_TALK);
        talk(ROLE_MODEM_TALK);
        // Terminal listener: carrier gates reception
        role = ROLE_TERM_LISTEN;
        b = rnd();
        exp_q.push_back(b);
        i_partner.send_char(b);
        wait_cycles(2 * BC);
        cd_in = 1'b0;
        i_partner.send_char(rnd());
        wait_cycles(2 * BC);
        check_bit(exp_q.size() == 0, 1'b1);
        // Modem listener: turnaround and receive
        role = ROLE_MODEM_LISTEN;
        @(negedge clk_sys_in);
        rts_in = 1'b1;
        wait_cycles(1);
        check_bit(cts_out, 1'b0);
        wait_cycles(TC + 3);
        check_bit(cts_out, 1'b1);
        b = rnd();
        exp_q.push_back(b);
        i_partner.send_char(b);
        wait_cycles(2 * BC);
        rts_in = 1'b0;
        wait_cycles(2);
        check_bit(cts_out, 1'b0);
        check_bit(exp_q.size() == 0, 1'b1);
        // Monitor mode over the current loop, modem controls inactive, cts included, which is held low
        monitor = 1'b1;
        loop_mode = 1'b1;
        role = ROLE_TERM_LISTEN;
        dtr_in = 1'b0;
        wait_cycles(2);
        check_bit(loop_sel, 1'b1);
        i_partner.send_char(CHAR_CMD_PREFIX);
        for (int i = 0; i < 2; i++) begin
            b = 8'h61 + 8'(i);
            exp_q.push_back(b);
            i_partner.send_char(b);
        end
        i_partner.send_char(CHAR_CMD_END);
        wait_cycles(2 * BC);
        check_bit(exp_q.size() == 0, 1'b1);
        check_byte(8'(n_end), 8'h01);
        cmd_finish(1'b1);
        cmd_finish(1'b0);
        finish_test();
    end

    // Run needs under two thousand cycles; this bound is well past that
    initial begin
        #200_000;
        errors++;
        finish_test();
    end
endmodule
`default_nettype wire
